// *** rtl/fpk_pkg.sv ***
package fpk_pkg;
   // =========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_ACCESS    = 8'h00;
   localparam logic [7:0] OFS_BANK_EN   = 8'h04;
   localparam logic [7:0] OFS_CI_EN     = 8'h08;
   localparam logic [7:0] OFS_CI_PULSED = 8'h0c;
   localparam logic [7:0] OFS_CI_CMD_LO = 8'h10;
   localparam logic [7:0] OFS_CI_CMD_HI = 8'h14;
   localparam logic [7:0] OFS_FK_EN     = 8'h18;
   localparam logic [7:0] OFS_FK_LOCK   = 8'h1c;
   localparam logic [7:0] OFS_FK_MODE   = 8'h20;
   localparam logic [7:0] OFS_FK_MINP   = 8'h24;
   localparam logic [7:0] OFS_FK_STATE  = 8'h28;
   localparam logic [7:0] OFS_CI_STATE  = 8'h2c;
   localparam logic [7:0] OFS_MENU_STAT = 8'h30;

   // =========================================================
   // direct access settings
   localparam logic [1:0] ACC_DISABLED          = 2'h0;
   localparam logic [1:0] ACC_ENABLED           = 2'h1;
   localparam logic [1:0] ACC_BREAKER_KEYS_ONLY = 2'h2;
   localparam logic [1:0] ACC_SHORTCUT_ONLY     = 2'h3;

   // control input command pairs
   localparam logic [1:0] CMD_ON_OFF           = 2'h0;
   localparam logic [1:0] CMD_SET_RESET        = 2'h1;
   localparam logic [1:0] CMD_IN_OUT           = 2'h2;
   localparam logic [1:0] CMD_ENABLED_DISABLED = 2'h3;

   // =========================================================
   // reset values
   localparam logic [1:0]  RST_ACCESS    = ACC_DISABLED;
   localparam logic [3:0]  RST_BANK_EN   = 4'h1;
   localparam logic [31:0] RST_CI_EN     = 32'hffff_ffff;
   localparam logic [31:0] RST_CI_PULSED = 32'h0000_0000;
   localparam logic [31:0] RST_CI_CMD    = 32'h5555_5555;
   localparam logic [9:0]  RST_FK_EN     = 10'h3ff;
   localparam logic [9:0]  RST_FK_LOCK   = 10'h000;
   localparam logic [9:0]  RST_FK_MODE   = 10'h000;
   localparam logic [15:0] RST_FK_MINP   = 16'h0000;

   // =========================================================
   // timing and bus response codes
   localparam int CLK_HZ          = 100_000_000;
   localparam int CYC_PER_MS      = (CLK_HZ + 999) / 1000;
   localparam int MENU_TIMEOUT_MS = 20_000;
   localparam int PRESS_MIN_MS    = 200;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // =========================================================
   // types
   typedef struct packed {
      logic hot_left;
      logic hot_right;
      logic cur_left;
      logic cur_right;
   } panel_keys_t;

   typedef struct packed {
      logic open_cmd;
      logic close_cmd;
   } breaker_cmd_t;

   typedef enum logic [1:0] {MENU_IDLE, MENU_NAV, MENU_BREAKER} menu_state_t;

endpackage

// *** rtl/front_panel_key_control.sv ***
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
// Contract
// [R1] direct access setting takes disabled, enabled, breaker keys only, shortcut only
// [R2] bank and input hotkeys need enabled/shortcut; breaker keys need enabled/breaker-only
// [R3] only bank 1 enabled after reset; hotkey offers only enabled banks
// [R4] no cursor key for 20 s inside hotkey menu returns to idle
// [R5] per control input: hotkey enable, latched or pulsed, command pair
// [R6] all 32 inputs hotkey enabled, latched, set/reset after reset
// [R7] menu top: two rights reach first input, one left reaches last
// [R8] breaker access off by default; offers close when open, open when closed
// [R9] breaker key first asks cancel or confirm; acts only on confirm
// [R10] readable 10 bit function key state word
// [R11] locked toggled key that is active stays active, presses ignored
// [R12] locked normal key output forced inactive
// [R13] toggled key: one press sets, next press clears
// [R14] normal key: output only while key held
// [R15] optional minimum output pulse width for function key output
// [R16] toggled key states saved to and restored from non-volatile store
// [R17] one function key press recognised at a time, others ignored
// [R18] press passed on only after about 200 ms held
// [R19] each function key individually enabled and lockable
// [R20] press and menu times counted on a millisecond tick
// [R21] release before threshold restarts count and changes nothing
module front_panel_key_control #(
   parameter int NUM_BANKS       = 4,
   parameter int CLK_PER_MS      = fpk_pkg::CYC_PER_MS,
   parameter int MENU_TIMEOUT_MS = fpk_pkg::MENU_TIMEOUT_MS,
   parameter int PRESS_MIN_MS    = fpk_pkg::PRESS_MIN_MS
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // operator keypad pins
   input  wire fpk_pkg::panel_keys_t panel_keys,
   input  wire logic [9:0]           fn_key_pins,
   // scheme logic side
   input  wire logic                 breaker_closed,
   output fpk_pkg::breaker_cmd_t     breaker_cmd,
   output logic [31:0]               ci_state,
   output logic [31:0]               ci_pulse,
   output logic [9:0]                fk_out,
   output logic [1:0]                active_bank,
   output logic                      menu_active,
   // non-volatile store
   input  wire logic [9:0]           nv_word,
   output logic [9:0]                nv_save_word
);

   if (NUM_BANKS < 1 || NUM_BANKS > 4) $error("NUM_BANKS must be 1 to 4");
   if (CLK_PER_MS < 1 || CLK_PER_MS > 131072 || PRESS_MIN_MS < 1 || PRESS_MIN_MS > 255) $error("bad timing parameter");
   if (MENU_TIMEOUT_MS < 1 || MENU_TIMEOUT_MS > 65535) $error("bad menu timeout");

   localparam logic [16:0] TICK_LAST = 17'(CLK_PER_MS - 1);
   localparam logic [15:0] MENU_LAST = 16'(MENU_TIMEOUT_MS - 1);
   localparam logic [7:0]  PRESS_LAST = 8'(PRESS_MIN_MS - 1);
   localparam logic [5:0]  POS_LAST = 6'h21;

   function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
      end
      return r;
   endfunction

   // =========================================================
   // millisecond tick
   logic [16:0] tick_cnt_q;
   logic        tick_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_cnt_q <= 17'h0;
         tick_q     <= 1'b0;
      end else begin
         tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 17'h0 : tick_cnt_q + 17'h1;
         tick_q     <= (tick_cnt_q == TICK_LAST); // R20
      end
   end

   // =========================================================
   // key synchronisers and filter
   logic [13:0] key_s1_q, key_s2_q, key_s3_q, key_clean_q, key_prev_q;
   wire  [13:0] key_raw   = {panel_keys, fn_key_pins};
   wire  [13:0] key_agree = ~(key_s2_q ^ key_s3_q);
   wire  [13:0] key_press = key_clean_q & ~key_prev_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         key_s1_q    <= 14'h0;
         key_s2_q    <= 14'h0;
         key_s3_q    <= 14'h0;
         key_clean_q <= 14'h0;
         key_prev_q  <= 14'h0;
      end else begin
         key_s1_q    <= key_raw;
         key_s2_q    <= key_s1_q;
         key_s3_q    <= key_s2_q;
         key_clean_q <= (key_agree & key_s3_q) | (~key_agree & key_clean_q);
         key_prev_q  <= key_clean_q;
      end
   end
   wire       hot_l_p = key_press[13];
   wire       hot_r_p = key_press[12];
   wire       cur_l_p = key_press[11];
   wire       cur_r_p = key_press[10];
   wire [9:0] fn_held = key_clean_q[9:0];

   // =========================================================
   // configuration registers
   logic [1:0]  access_q;
   logic [3:0]  bank_en_q;
   logic [31:0] ci_en_q, ci_pulsed_q, ci_cmd_lo_q, ci_cmd_hi_q;
   logic [9:0]  fk_en_q, fk_lock_q, fk_mode_q;
   logic [15:0] fk_minp_q;

   // =========================================================
   // axi4-lite write path
   logic        aw_hold_q, w_hold_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   wire         aw_take  = s_axi_awvalid & s_axi_awready;
   wire         w_take   = s_axi_wvalid & s_axi_wready;
   wire         do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   wire         aw_hold_d = aw_hold_q ? ~do_write : aw_take;
   wire         w_hold_d  = w_hold_q ? ~do_write : w_take;
   wire [31:0]  wr_cur;
   wire         wr_hit = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= fpk_pkg::OFS_FK_MINP);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         awaddr_q      <= 8'h0;
         wdata_q       <= 32'h0;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= fpk_pkg::RESP_OKAY;
      end else begin
         aw_hold_q     <= aw_hold_d;
         w_hold_q      <= w_hold_d;
         s_axi_awready <= ~aw_hold_d;
         s_axi_wready  <= ~w_hold_d;
         if (aw_take) awaddr_q <= s_axi_awaddr;
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? fpk_pkg::RESP_OKAY : fpk_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign wr_cur = (awaddr_q == fpk_pkg::OFS_ACCESS)    ? {30'h0, access_q} :
                   (awaddr_q == fpk_pkg::OFS_BANK_EN)   ? {28'h0, bank_en_q} :
                   (awaddr_q == fpk_pkg::OFS_CI_EN)     ? ci_en_q :
                   (awaddr_q == fpk_pkg::OFS_CI_PULSED) ? ci_pulsed_q :
                   (awaddr_q == fpk_pkg::OFS_CI_CMD_LO) ? ci_cmd_lo_q :
                   (awaddr_q == fpk_pkg::OFS_CI_CMD_HI) ? ci_cmd_hi_q :
                   (awaddr_q == fpk_pkg::OFS_FK_EN)     ? {22'h0, fk_en_q} :
                   (awaddr_q == fpk_pkg::OFS_FK_LOCK)   ? {22'h0, fk_lock_q} :
                   (awaddr_q == fpk_pkg::OFS_FK_MODE)   ? {22'h0, fk_mode_q} :
                   {16'h0, fk_minp_q};
   wire [31:0] wr_val = merge_strb(wr_cur, wdata_q, wstrb_q);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         access_q    <= fpk_pkg::RST_ACCESS;    // R1 R8
         bank_en_q   <= fpk_pkg::RST_BANK_EN;   // R3
         ci_en_q     <= fpk_pkg::RST_CI_EN;     // R6
         ci_pulsed_q <= fpk_pkg::RST_CI_PULSED; // R6
         ci_cmd_lo_q <= fpk_pkg::RST_CI_CMD;    // R6
         ci_cmd_hi_q <= fpk_pkg::RST_CI_CMD;
         fk_en_q     <= fpk_pkg::RST_FK_EN;
         fk_lock_q   <= fpk_pkg::RST_FK_LOCK;
         fk_mode_q   <= fpk_pkg::RST_FK_MODE;
         fk_minp_q   <= fpk_pkg::RST_FK_MINP;
      end else if (do_write) begin
         case (awaddr_q)
            fpk_pkg::OFS_ACCESS:    access_q    <= wr_val[1:0]; // R1
            fpk_pkg::OFS_BANK_EN:   bank_en_q   <= wr_val[3:0] | 4'h1;
            fpk_pkg::OFS_CI_EN:     ci_en_q     <= wr_val;      // R5
            fpk_pkg::OFS_CI_PULSED: ci_pulsed_q <= wr_val;      // R5
            fpk_pkg::OFS_CI_CMD_LO: ci_cmd_lo_q <= wr_val;      // R5
            fpk_pkg::OFS_CI_CMD_HI: ci_cmd_hi_q <= wr_val;
            fpk_pkg::OFS_FK_EN:     fk_en_q     <= wr_val[9:0]; // R19
            fpk_pkg::OFS_FK_LOCK:   fk_lock_q   <= wr_val[9:0]; // R19
            fpk_pkg::OFS_FK_MODE:   fk_mode_q   <= wr_val[9:0];
            fpk_pkg::OFS_FK_MINP:   fk_minp_q   <= wr_val[15:0]; // R15
            default: ;
         endcase
      end
   end

   // =========================================================
   // hotkey menu
   fpk_pkg::menu_state_t st_q, st_d;
   logic [5:0]  pos_q, pos_d;
   logic [1:0]  cand_q, cand_d, bank_q, bank_d;
   logic [15:0] idle_q, idle_d;
   logic [31:0] ci_q, ci_d, ci_pulse_d;
   logic        close_sel_q, close_sel_d;
   fpk_pkg::breaker_cmd_t brk_d;

   wire       hot_ok = (access_q == fpk_pkg::ACC_ENABLED) || (access_q == fpk_pkg::ACC_SHORTCUT_ONLY);
   wire       brk_ok = (access_q == fpk_pkg::ACC_ENABLED) || (access_q == fpk_pkg::ACC_BREAKER_KEYS_ONLY);
   wire [4:0] ci_idx = 5'(pos_q - 6'h2);
   wire [3:0] bank_ok = bank_en_q & 4'((5'h1 << NUM_BANKS) - 5'h1);

   function automatic logic [1:0] next_bank(input logic [1:0] cur, input logic [3:0] en);
      logic [1:0] r;
      logic       found;
      r = cur;
      found = 1'b0;
      for (int i = 1; i < 4; i++) begin
         if (!found && en[2'(cur + 2'(i))]) begin
            r = 2'(cur + 2'(i));
            found = 1'b1;
         end
      end
      return r;
   endfunction

   always_comb begin
      st_d        = st_q;
      pos_d       = pos_q;
      cand_d      = cand_q;
      bank_d      = bank_q;
      ci_d        = ci_q;
      ci_pulse_d  = 32'h0;
      close_sel_d = close_sel_q;
      brk_d       = '0;
      idle_d      = idle_q;
      if (cur_l_p || cur_r_p) begin
         idle_d = 16'h0;
      end else if (tick_q) begin
         idle_d = idle_q + 16'h1;
      end
      case (st_q)
         fpk_pkg::MENU_IDLE: begin
            idle_d = 16'h0;
            if (hot_l_p && hot_ok) begin // R2
               st_d   = fpk_pkg::MENU_NAV;
               pos_d  = 6'h0;
               cand_d = next_bank(bank_q, bank_ok); // R3
            end else if (hot_r_p && brk_ok) begin // R2
               st_d        = fpk_pkg::MENU_BREAKER; // R9
               close_sel_d = ~breaker_closed; // R8
            end
         end
         fpk_pkg::MENU_NAV: begin
            if (cur_r_p) pos_d = (pos_q == POS_LAST) ? 6'h0 : pos_q + 6'h1; // R7
            if (cur_l_p) pos_d = (pos_q == 6'h0) ? POS_LAST : pos_q - 6'h1; // R7
            if (pos_q == 6'h1) begin
               if (hot_l_p) cand_d = next_bank(cand_q, bank_ok); // R3
               if (hot_r_p && bank_ok[cand_q]) bank_d = cand_q;   // R3
            end else if (hot_l_p) begin
               st_d = fpk_pkg::MENU_IDLE;
            end else if (hot_r_p && pos_q != 6'h0 && ci_en_q[ci_idx]) begin // R5
               if (ci_pulsed_q[ci_idx]) ci_pulse_d[ci_idx] = 1'b1;
               else ci_d[ci_idx] = ~ci_q[ci_idx];
            end
         end
         fpk_pkg::MENU_BREAKER: begin
            if (hot_l_p) begin
               st_d = fpk_pkg::MENU_IDLE;
            end else if (hot_r_p) begin
               st_d = fpk_pkg::MENU_IDLE;
               brk_d.close_cmd = close_sel_q & brk_ok;  // R9
               brk_d.open_cmd  = ~close_sel_q & brk_ok; // R9
            end
         end
         default: st_d = fpk_pkg::MENU_IDLE;
      endcase
      if (st_q != fpk_pkg::MENU_IDLE && tick_q && idle_q >= MENU_LAST && !(cur_l_p || cur_r_p)) begin
         st_d = fpk_pkg::MENU_IDLE; // R4
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q        <= fpk_pkg::MENU_IDLE;
         pos_q       <= 6'h0;
         cand_q      <= 2'h0;
         bank_q      <= 2'h0;
         idle_q      <= 16'h0;
         ci_q        <= 32'h0;
         close_sel_q <= 1'b0;
         ci_pulse    <= 32'h0;
         breaker_cmd <= '0;
         menu_active <= 1'b0;
      end else begin
         st_q        <= st_d;
         pos_q       <= pos_d;
         cand_q      <= cand_d;
         bank_q      <= bank_d;
         idle_q      <= idle_d; // R20
         ci_q        <= ci_d;
         close_sel_q <= close_sel_d;
         ci_pulse    <= ci_pulse_d;
         breaker_cmd <= brk_d;
         menu_active <= (st_d != fpk_pkg::MENU_IDLE);
      end
   end
   assign ci_state    = ci_q;
   assign active_bank = bank_q;

   // =========================================================
   // function keys
   logic        own_q, own_d, recog_q, recog_d, restore_q;
   logic [3:0]  owner_q, owner_d, minp_key_q, minp_key_d;
   logic [7:0]  press_q, press_d;
   logic [15:0] minp_q, minp_d;
   logic [9:0]  tog_q, tog_d, fk_d;
   wire  [9:0]  fn_cand = fn_held & fk_en_q;

   function automatic logic [3:0] lowest_key(input logic [9:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 9; i >= 0; i--) begin
         if (v[i]) r = 4'(i);
      end
      return r;
   endfunction

   always_comb begin
      own_d      = own_q;
      owner_d    = owner_q;
      recog_d    = recog_q;
      press_d    = press_q;
      minp_key_d = minp_key_q;
      tog_d      = tog_q;
      minp_d     = (tick_q && minp_q != 16'h0) ? minp_q - 16'h1 : minp_q;
      if (!own_q) begin
         if (fn_cand != 10'h0) begin // R17
            own_d   = 1'b1;
            owner_d = lowest_key(fn_cand);
            press_d = 8'h0;
            recog_d = 1'b0;
         end
      end else if (!fn_held[owner_q]) begin
         own_d   = 1'b0; // R17
         recog_d = 1'b0;
         press_d = 8'h0; // R21
      end else if (!recog_q && tick_q) begin
         if (press_q == PRESS_LAST) begin
            recog_d = 1'b1; // R18
            if (fk_mode_q[owner_q] && !fk_lock_q[owner_q]) begin
               tog_d[owner_q] = ~tog_q[owner_q]; // R13 R11
            end else if (!fk_mode_q[owner_q]) begin
               minp_d     = fk_minp_q; // R15
               minp_key_d = owner_q;
            end
         end else begin
            press_d = press_q + 8'h1; // R20
         end
      end
      if (restore_q) tog_d = nv_word; // R16
      for (int i = 0; i < 10; i++) begin
         if (fk_mode_q[i]) begin
            fk_d[i] = tog_q[i]; // R11 R13
         end else begin
            fk_d[i] = ~fk_lock_q[i] & ((own_q && recog_q && owner_q == 4'(i)) || // R12 R14
                      (minp_q != 16'h0 && minp_key_q == 4'(i)));
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         own_q        <= 1'b0;
         owner_q      <= 4'h0;
         recog_q      <= 1'b0;
         press_q      <= 8'h0;
         minp_q       <= 16'h0;
         minp_key_q   <= 4'h0;
         tog_q        <= 10'h0;
         restore_q    <= 1'b1;
         fk_out       <= 10'h0;
         nv_save_word <= 10'h0;
      end else begin
         own_q        <= own_d;
         owner_q      <= owner_d;
         recog_q      <= recog_d;
         press_q      <= press_d;
         minp_q       <= minp_d;
         minp_key_q   <= minp_key_d;
         tog_q        <= tog_d;
         restore_q    <= 1'b0;
         fk_out       <= fk_d;
         nv_save_word <= tog_d; // R16
      end
   end

   // =========================================================
   // axi4-lite read path
   logic [31:0] rd_mux;
   wire         ar_take  = s_axi_arvalid & s_axi_arready;
   wire         rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
   wire [31:0]  menu_stat = {19'h0, close_sel_q, cand_q, pos_q, bank_q, st_q};
   always_comb begin
      case (s_axi_araddr)
         fpk_pkg::OFS_ACCESS:    rd_mux = {30'h0, access_q};
         fpk_pkg::OFS_BANK_EN:   rd_mux = {28'h0, bank_en_q};
         fpk_pkg::OFS_CI_EN:     rd_mux = ci_en_q;
         fpk_pkg::OFS_CI_PULSED: rd_mux = ci_pulsed_q;
         fpk_pkg::OFS_CI_CMD_LO: rd_mux = ci_cmd_lo_q;
         fpk_pkg::OFS_CI_CMD_HI: rd_mux = ci_cmd_hi_q;
         fpk_pkg::OFS_FK_EN:     rd_mux = {22'h0, fk_en_q};
         fpk_pkg::OFS_FK_LOCK:   rd_mux = {22'h0, fk_lock_q};
         fpk_pkg::OFS_FK_MODE:   rd_mux = {22'h0, fk_mode_q};
         fpk_pkg::OFS_FK_MINP:   rd_mux = {16'h0, fk_minp_q};
         fpk_pkg::OFS_FK_STATE:  rd_mux = {22'h0, fk_out}; // R10
         fpk_pkg::OFS_CI_STATE:  rd_mux = ci_q;
         fpk_pkg::OFS_MENU_STAT: rd_mux = menu_stat;
         default:                rd_mux = 32'h0;
      endcase
   end
   wire rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= fpk_pkg::OFS_MENU_STAT);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= fpk_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid  <= rvalid_d;
         if (ar_take) begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? fpk_pkg::RESP_OKAY : fpk_pkg::RESP_SLVERR;
         end
      end
   end

endmodule // front_panel_key_control

// *** sim/keypad_model.sv ***
`timescale 1ns/1ns
// operator keypad: keys idle low, pressed keys drive high
module keypad_model (
   input  wire logic          core_clk,
   output fpk_pkg::panel_keys_t panel_keys,
   output logic [9:0]          fn_key_pins
);
   initial begin
      panel_keys = '0;
      fn_key_pins = '0;
   end
   // hold the given keys for n cycles, then stay idle for 8 cycles
   task automatic tap(input logic [3:0] k, input logic [9:0] f, input int n);
      @(posedge core_clk);
      panel_keys <= k;
      fn_key_pins <= f;
      repeat (n) @(posedge core_clk);
      panel_keys <= '0;
      fn_key_pins <= '0;
      repeat (8) @(posedge core_clk);
   endtask
endmodule // keypad_model

// *** sim/front_panel_key_control_chk.sv ***
`timescale 1ns/1ns
module fpk_chk (
   input wire logic core_clk, rst, s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
   input wire logic s_axi_arvalid, s_axi_arready, breaker_closed, menu_active,
   input wire logic [1:0] s_axi_bresp, s_axi_rresp,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [9:0] fn_key_pins, fk_out,
   input wire fpk_pkg::breaker_cmd_t breaker_cmd
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   rd_slverr_a: assert property (rd_take ##0 s_axi_araddr > 8'h30 |=> s_axi_rresp == fpk_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
   state_word_a: assert property (rd_take ##0 s_axi_araddr == fpk_pkg::OFS_FK_STATE
      |=> s_axi_rdata[9:0] == $past(fk_out)) else $error("key state word wrong");
   cmd_pulse_a: assert property (|breaker_cmd |=> breaker_cmd == '0)
      else $error("breaker command longer than one cycle");
   cmd_confirm_a: assert property (|breaker_cmd |-> $past(menu_active))
      else $error("breaker command without confirm step");
   cmd_dir_a: assert property (|breaker_cmd |-> breaker_cmd.open_cmd == breaker_closed)
      else $error("breaker action wrong way round");
   fk_hold_a: assert property ((fk_out & ~$past(fk_out)) != '0 |-> $past(fn_key_pins, 6) != '0)
      else $error("key output rose without a held press");
endmodule // fpk_chk
bind front_panel_key_control fpk_chk fpk_chk_inst (.*);

// *** sim/front_panel_key_control_tb.sv ***
`timescale 1ns/1ns
module front_panel_key_control_tb;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
   logic core_clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, bc = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd_d, ci_state;
   logic awr, wrr, bv, arr, rv, menu_active, seen_menu;
   logic [1:0] bresp, rresp, r, seen_cmd;
   logic [9:0] fk_out, fn, seen_fk;
   fpk_pkg::panel_keys_t keys;
   fpk_pkg::breaker_cmd_t bcmd;
   int bad_count = 0, n_checks = 0;
   row_t rows [11] = '{'{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h1, 2'h0}, '{8'h08, 32'hffff_ffff, 2'h0},
      '{8'h0c, 32'h0, 2'h0}, '{8'h10, 32'h5555_5555, 2'h0}, '{8'h14, 32'h5555_5555, 2'h0},
      '{8'h18, 32'h3ff, 2'h0}, '{8'h1c, 32'h0, 2'h0}, '{8'h20, 32'h0, 2'h0}, '{8'h24, 32'h0, 2'h0},
      '{8'h40, 32'h0, 2'h2}};
   always #5 core_clk = ~core_clk;
   front_panel_key_control #(.CLK_PER_MS(4), .MENU_TIMEOUT_MS(8), .PRESS_MIN_MS(3)) front_panel_key_control_inst (
      .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .panel_keys(keys),
      .fn_key_pins(fn), .breaker_closed(bc), .breaker_cmd(bcmd), .ci_state(ci_state), .ci_pulse(),
      .fk_out(fk_out), .active_bank(), .menu_active(menu_active), .nv_word(10'h0), .nv_save_word());
   keypad_model keypad_model_inst (.core_clk(core_clk), .panel_keys(keys), .fn_key_pins(fn));
   always @(posedge core_clk) begin
      {seen_cmd, seen_menu, seen_fk} <= {seen_cmd | bcmd, seen_menu | menu_active, seen_fk | fk_out};
   end
   task automatic clr;
      @(negedge core_clk);
      {seen_cmd, seen_menu, seen_fk} = '0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge core_clk);
      {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
      do begin
         @(posedge core_clk);
         if (awr) awv <= 0;
         if (wrr) wv <= 0;
      end while (awv || wv);
      do @(posedge core_clk); while (!bv);
      rs = bresp;
      bry <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge core_clk);
      {ara, arv, rry} <= {a, 2'b11};
      do @(posedge core_clk); while (!arr);
      arv <= 0;
      do @(posedge core_clk); while (!rv);
      {d, rs} = {rd_d, rresp};
      rry <= 0;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      logic [31:0] d;
      repeat (2) @(posedge core_clk);
      rst <= 0;
      repeat (2) @(posedge core_clk);
      foreach (rows[i]) begin
         rd(rows[i].a, d, r);
         chk(d, rows[i].d);
         chk(r, rows[i].r);
      end
      $display("reset values done");
      clr;
      keypad_model_inst.tap(4'h4, 0, 6);
      chk(seen_menu, 0);
      wr(fpk_pkg::OFS_ACCESS, fpk_pkg::ACC_BREAKER_KEYS_ONLY, r);
      keypad_model_inst.tap(4'h8, 0, 6);
      chk(seen_menu, 0);
      keypad_model_inst.tap(4'h4, 0, 6);
      chk(menu_active, 1);
      keypad_model_inst.tap(4'h4, 0, 6);
      chk(seen_cmd, 2'b01);
      bc <= 1;
      clr;
      repeat (2) keypad_model_inst.tap(4'h4, 0, 6);
      chk(seen_cmd, 2'b10);
      $display("breaker done");
      wr(fpk_pkg::OFS_ACCESS, fpk_pkg::ACC_SHORTCUT_ONLY, r);
      keypad_model_inst.tap(4'h8, 0, 6);
      repeat (2) keypad_model_inst.tap(4'h1, 0, 6);
      keypad_model_inst.tap(4'h4, 0, 6);
      chk(ci_state, 32'h1);
      repeat (3) keypad_model_inst.tap(4'h2, 0, 6);
      keypad_model_inst.tap(4'h4, 0, 6);
      chk(ci_state, 32'h8000_0001);
      repeat (60) @(posedge core_clk);
      chk(menu_active, 0);
      $display("menu done");
      wr(fpk_pkg::OFS_FK_MODE, 1, r);
      keypad_model_inst.tap(0, 10'h1, 30);
      chk(fk_out, 1);
      rd(fpk_pkg::OFS_FK_STATE, d, r);
      chk(d, 1);
      keypad_model_inst.tap(0, 10'h1, 6);
      chk(fk_out, 1);
      wr(fpk_pkg::OFS_FK_LOCK, 1, r);
      keypad_model_inst.tap(0, 10'h1, 30);
      chk(fk_out, 1);
      wr(fpk_pkg::OFS_FK_LOCK, 0, r);
      keypad_model_inst.tap(0, 10'h1, 30);
      chk(fk_out, 0);
      clr;
      keypad_model_inst.tap(0, 10'h2, 30);
      chk(seen_fk, 2);
      chk(fk_out, 0);
      clr;
      keypad_model_inst.tap(0, 10'h6, 30);
      chk(seen_fk, 2);
      wr(fpk_pkg::OFS_FK_LOCK, 2, r);
      clr;
      keypad_model_inst.tap(0, 10'h2, 30);
      chk(seen_fk, 0);
      wr(fpk_pkg::OFS_FK_STATE, 0, r);
      chk(r, fpk_pkg::RESP_SLVERR);
      $display("function keys done");
      wrap_up;
   end
   initial begin
      #300000;
      bad_count++;
      wrap_up;
   end
endmodule // front_panel_key_control_tb
